/* File: rtl/ptmr_defs.svh */
// Register offsets, field positions, reset values and timing counts of the period timer
`ifndef PTMR_DEFS_SVH
`define PTMR_DEFS_SVH

`define PTMR_ADDR_W            3
`define PTMR_OFF_CONTROL       3'h0
`define PTMR_OFF_COUNT         3'h1
`define PTMR_OFF_PERIOD        3'h2
`define PTMR_OFF_FLAGS         3'h3
`define PTMR_OFF_ENABLES       3'h4
`define PTMR_OFF_GLOBAL        3'h5
`define PTMR_OFF_IRQ_STATUS    3'h6
`define PTMR_OFF_IRQ_MASK      3'h7

`define PTMR_POST_MSB          6
`define PTMR_POST_LSB          3
`define PTMR_RUN_BIT           2
`define PTMR_PRE_MSB           1
`define PTMR_PRE_LSB           0
`define PTMR_FLAG_BIT          1
`define PTMR_GIE_BIT           7
`define PTMR_PEIE_BIT          6
`define PTMR_CONTROL_MASK      8'h7f

`define PTMR_CONTROL_RST       7'h00
`define PTMR_COUNT_RST         8'h00
`define PTMR_PERIOD_RST        8'hff
`define PTMR_FLAGS_RST         8'h00
`define PTMR_ENABLES_RST       8'h00
`define PTMR_GLOBAL_RST        8'h00
`define PTMR_IRQ_RST           2'h0

`define PTMR_PRE_DIV1_LAST     4'h0
`define PTMR_PRE_DIV4_LAST     4'h3
`define PTMR_PRE_DIV16_LAST    4'hf
`define PTMR_INSTR_DIV_LAST    2'h3

`endif

/* File: rtl/ptmr_pkg.sv */
// Types shared by the period timer
package ptmr_pkg;

	typedef struct packed {
		logic [3:0] postscale_select;
		logic       run_enable;
		logic [1:0] prescale_select;
	} ptmr_control_t;

	// Sticky event bits: bit 1 = postscaler fired, bit 0 = period match
	typedef struct packed {
		ptmr_control_t control;
		logic [7:0]    count_value;
		logic [7:0]    period_compare_value;
		logic [7:0]    peripheral_interrupt_flags;
		logic [7:0]    peripheral_interrupt_enables;
		logic [7:0]    global_interrupt_control;
		logic [1:0]    instr_phase;
		logic [3:0]    prescale_count;
		logic [3:0]    postscale_count;
		logic [1:0]    irq_status;
		logic [1:0]    irq_mask;
		logic [7:0]    rdata;
	} ptmr_state_t;

endpackage

/* File: rtl/ptmr_timer.sv */
// Eight-bit period timer with prescaler, postscaler, register port and interrupt
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`include "ptmr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module ptmr_timer (
	// Clock and reset; ref_clk is the oscillator
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// Register port
	input  wire logic [`PTMR_ADDR_W-1:0]  addr,
	input  wire logic [7:0]               wdata,
	input  wire logic                     wr_stb,
	input  wire logic                     rd_stb,
	output logic      [7:0]               rdata,
	// Interrupt and event outputs
	output logic                          irq,
	output logic                          period_irq_req,
	output logic                          match_tick
);

	ptmr_pkg::ptmr_state_t s_reg;
	ptmr_pkg::ptmr_state_t s_next;

	logic       instr_tick;
	logic       pre_tick;
	logic       count_step;
	logic       match;
	logic       post_fire;
	logic       wr_control;
	logic       wr_count;
	logic       wr_period;
	logic       wr_flags;
	logic       wr_enables;
	logic       wr_global;
	logic       wr_mask;
	logic       rd_status;
	logic [3:0] pre_last;
	logic [1:0] irq_events;

	// Terminal value of the prescaler counter for a select code
	function automatic logic [3:0] pre_limit(input logic [1:0] sel);
		if (sel[1]) begin
			return `PTMR_PRE_DIV16_LAST;
		end else if (sel[0]) begin
			return `PTMR_PRE_DIV4_LAST;
		end else begin
			return `PTMR_PRE_DIV1_LAST;
		end
	endfunction

	// Write or read strobe decode for one register offset
	function automatic logic hit(input logic [`PTMR_ADDR_W-1:0] a, input logic [`PTMR_ADDR_W-1:0] off,
	                             input logic stb);
		return stb && (a == off);
	endfunction

	assign wr_control = hit(addr, `PTMR_OFF_CONTROL, wr_stb);
	assign wr_count   = hit(addr, `PTMR_OFF_COUNT, wr_stb);
	assign wr_period  = hit(addr, `PTMR_OFF_PERIOD, wr_stb);
	assign wr_flags   = hit(addr, `PTMR_OFF_FLAGS, wr_stb);
	assign wr_enables = hit(addr, `PTMR_OFF_ENABLES, wr_stb);
	assign wr_global  = hit(addr, `PTMR_OFF_GLOBAL, wr_stb);
	assign wr_mask    = hit(addr, `PTMR_OFF_IRQ_MASK, wr_stb);
	assign rd_status  = hit(addr, `PTMR_OFF_IRQ_STATUS, rd_stb);

	// Instruction clock is one tick in four oscillator cycles
	assign instr_tick = (s_reg.instr_phase == `PTMR_INSTR_DIV_LAST);
	assign pre_last   = pre_limit(s_reg.control.prescale_select);
	assign pre_tick   = instr_tick && s_reg.control.run_enable && (s_reg.prescale_count == pre_last);
	// Software writes to count or control take priority over counting
	assign count_step = pre_tick && !wr_count && !wr_control;
	assign match      = (s_reg.count_value == s_reg.period_compare_value);
	assign post_fire  = count_step && match &&
	                    (s_reg.postscale_count == s_reg.control.postscale_select);
	assign irq_events = {post_fire, count_step && match};

	always_comb begin
		s_next = s_reg;

		s_next.instr_phase = s_reg.instr_phase + 2'h1;

		// Prescaler
		if (wr_count || wr_control) begin
			s_next.prescale_count = 4'h0;
		end else if (instr_tick && s_reg.control.run_enable) begin
			if (s_reg.prescale_count == pre_last) begin
				s_next.prescale_count = 4'h0;
			end else begin
				s_next.prescale_count = s_reg.prescale_count + 4'h1;
			end
		end

		// Counter; held while run enable is clear
		if (wr_count) begin
			s_next.count_value = wdata;
		end else if (count_step) begin
			if (match) begin
				s_next.count_value = 8'h00;
			end else begin
				s_next.count_value = s_reg.count_value + 8'h01;
			end
		end

		// Postscaler
		if (wr_count || wr_control) begin
			s_next.postscale_count = 4'h0;
		end else if (count_step && match) begin
			if (post_fire) begin
				s_next.postscale_count = 4'h0;
			end else begin
				s_next.postscale_count = s_reg.postscale_count + 4'h1;
			end
		end

		// Control write keeps the count
		if (wr_control) begin
			s_next.control = ptmr_pkg::ptmr_control_t'(wdata[6:0]);
		end
		if (wr_period) begin
			s_next.period_compare_value = wdata;
		end
		if (wr_enables) begin
			s_next.peripheral_interrupt_enables = wdata;
		end
		if (wr_global) begin
			s_next.global_interrupt_control = wdata;
		end

		// Flag register: hardware set wins over a software clear
		if (wr_flags) begin
			s_next.peripheral_interrupt_flags = wdata;
		end
		if (post_fire) begin
			s_next.peripheral_interrupt_flags[`PTMR_FLAG_BIT] = 1'b1;
		end

		// Sticky status, cleared by its read; new events win
		if (rd_status) begin
			s_next.irq_status = 2'h0;
		end
		s_next.irq_status = s_next.irq_status | irq_events;
		if (wr_mask) begin
			s_next.irq_mask = wdata[1:0];
		end

		// Read data stands the cycle after the strobe
		s_next.rdata = 8'h00;
		if (rd_stb) begin
			unique case (addr)
				`PTMR_OFF_CONTROL:    s_next.rdata = {1'b0, s_reg.control};
				`PTMR_OFF_COUNT:      s_next.rdata = s_reg.count_value;
				`PTMR_OFF_PERIOD:     s_next.rdata = s_reg.period_compare_value;
				`PTMR_OFF_FLAGS:      s_next.rdata = s_reg.peripheral_interrupt_flags;
				`PTMR_OFF_ENABLES:    s_next.rdata = s_reg.peripheral_interrupt_enables;
				`PTMR_OFF_GLOBAL:     s_next.rdata = s_reg.global_interrupt_control;
				`PTMR_OFF_IRQ_STATUS: s_next.rdata = {6'h00, s_reg.irq_status};
				`PTMR_OFF_IRQ_MASK:   s_next.rdata = {6'h00, s_reg.irq_mask};
			endcase
		end

		if (rst) begin
			s_next.control                      = ptmr_pkg::ptmr_control_t'(`PTMR_CONTROL_RST);
			s_next.count_value                  = `PTMR_COUNT_RST;
			s_next.period_compare_value         = `PTMR_PERIOD_RST;
			s_next.peripheral_interrupt_flags   = `PTMR_FLAGS_RST;
			s_next.peripheral_interrupt_enables = `PTMR_ENABLES_RST;
			s_next.global_interrupt_control     = `PTMR_GLOBAL_RST;
			s_next.instr_phase                  = 2'h0;
			s_next.prescale_count               = 4'h0;
			s_next.postscale_count              = 4'h0;
			s_next.irq_status                   = `PTMR_IRQ_RST;
			s_next.irq_mask                     = `PTMR_IRQ_RST;
			s_next.rdata                        = 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		s_reg <= s_next;
	end

	assign rdata          = s_reg.rdata;
	assign irq            = |(s_reg.irq_status & s_reg.irq_mask);
	// Core interrupt request: flag and enable, gated by the global and peripheral enables
	assign period_irq_req = s_reg.peripheral_interrupt_flags[`PTMR_FLAG_BIT] &&
	                        s_reg.peripheral_interrupt_enables[`PTMR_FLAG_BIT] &&
	                        s_reg.global_interrupt_control[`PTMR_GIE_BIT] &&
	                        s_reg.global_interrupt_control[`PTMR_PEIE_BIT];
	assign match_tick     = count_step && match;

endmodule

`default_nettype wire

/* File: sim/ptmr_timer_checker.sv */
// Port assertions for the period timer
`timescale 1ns/10ps
`default_nettype none
module ptmr_timer_checker (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst,
	// Register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [7:0] rdata,
	// Events
	input wire logic       irq,
	input wire logic       period_irq_req,
	input wire logic       match_tick
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence per_wr; wr_stb && addr == 3'h2; endsequence
	sequence per_rd; rd_stb && addr == 3'h2; endsequence
	rdata_idle_a: assert property (!rd_stb |=> rdata == 8'h00) else $error("rdata not idle");
	tick_space_a: assert property (match_tick |=> !match_tick [*3]) else $error("ticks too close");
	period_rw_a: assert property (per_wr ##1 per_rd |=> rdata == $past(wdata, 2)) else $error("period lost");
	ctl_msb_a: assert property (rd_stb && addr == 3'h0 |=> !rdata[7]) else $error("bit 7 set");
	wr_nostep_a: assert property (wr_stb && addr <= 3'h1 |-> !match_tick) else $error("step on write");
	req_hold_a: assert property (period_irq_req && !wr_stb |=> period_irq_req) else $error("flag lost");
	req_gate_a: assert property (wr_stb && addr == 3'h5 && wdata[7:6] != 2'b11 |=> !period_irq_req)
		else $error("request not gated");
	irq_hold_a: assert property (irq && !wr_stb && !(rd_stb && addr == 3'h6) |=> irq) else $error("irq lost");
endmodule
`default_nettype wire

/* File: sim/ptmr_timer_tb_top.sv */
// Self-checking testbench for the period timer
`timescale 1ns/10ps
`default_nettype none
module ptmr_timer_tb_top;
	logic       ref_clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic       irq, period_irq_req, match_tick;
	int         error_cnt, num_checks, seed = 32'he043;
	int         mdl[8] = '{0, 0, 255, 0, 0, 0, 0, 0};
	ptmr_timer ptmr_timer_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .irq(irq), .period_irq_req(period_irq_req), .match_tick(match_tick));
	initial forever #50 ref_clk = ~ref_clk;
	task results;
		if (error_cnt == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		wr_stb <= 1'b1; rd_stb <= 1'b0; addr <= a; wdata <= d;
		@(posedge ref_clk);
		mdl[a] = a == 3'h0 ? d & 8'h7f : a == 3'h7 ? d & 8'h03 : d;
	endtask
	task rd(input logic [2:0] a, input logic [31:0] e);
		rd_stb <= 1'b1; wr_stb <= 1'b0; addr <= a;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 cmp(rdata, e);
		@(posedge ref_clk);
	endtask
	task idle(input int n);
		wr_stb <= 1'b0; rd_stb <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask
	initial begin
		int per, div, post, m, n, cyc, last, gap;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++) rd(3'(a), mdl[a]);
		wr(3'h2, 8'($random(seed)));
		rd(3'h2, mdl[2]);
		wr(3'h0, 8'($random(seed)) & 8'hfb | 8'h80);
		wr(3'h1, 8'($random(seed)));
		rd(3'h1, mdl[1]);
		rd(3'h0, mdl[0]);
		wr(3'h3, 8'($random(seed)) & 8'hfd); wr(3'h4, 8'($random(seed))); wr(3'h5, 8'h40); wr(3'h7, 8'h03);
		for (int a = 3; a < 8; a++) rd(3'(a), mdl[a]);
		idle(100);
		rd(3'h1, mdl[1]);
		wr(3'h4, 8'h02); wr(3'h5, 8'hc0);
		for (int ps = 0; ps < 4; ps++) for (int k = 0; k < 3; k++) begin
			post = k == 0 ? 0 : k == 1 ? 3 : 15;
			div = ps == 0 ? 1 : ps == 1 ? 4 : 16;
			per = 1 + ($random(seed) & 3);
			m = $random(seed) & 3;
			wr(3'h0, 8'h00); wr(3'h2, 8'(per)); wr(3'h1, 8'h00); wr(3'h3, 8'h00); wr(3'h7, 8'(m));
			wr(3'h0, {1'b0, 4'(post), 1'b1, 2'(ps)});
			idle(1);
			n = 0; cyc = 0; last = 0; gap = 0;
			while (period_irq_req !== 1'b1 && cyc < 9000) begin
				@(posedge ref_clk);
				#1 cyc++;
				if (match_tick === 1'b1) begin
					n++;
					gap = cyc - last;
					last = cyc;
				end
			end
			cmp(n, post + 1);
			if (post > 0) cmp(gap, 4 * div * (per + 1));
			wr(3'h0, 8'h00);
			rd(3'h3, 8'h02);
			cmp(irq, m != 0);
			rd(3'h6, 8'h03);
			cmp(irq, 0);
		end
		results;
	end
	initial begin
		#4000000;
		error_cnt++;
		results;
	end
endmodule
bind ptmr_timer ptmr_timer_checker ptmr_timer_checker_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .period_irq_req(period_irq_req),
	.match_tick(match_tick));
`default_nettype wire
